// file: scc_pkg.sv
package scc_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int INSN_W = 12;
  localparam int PC_W = 11;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;

  // ****************************************
  // opcode fields
  // ****************************************
  localparam logic [3:0] OPC_SKIP_SET = 4'h7;
  localparam logic [3:0] OPC_CALL = 4'h9;
  localparam logic [6:0] OPC_CLEAR_F = 7'h03;
  localparam int BIT_LSB = 5;
  localparam int STAT_PAGE_LSB = 5;
  localparam int STAT_ZERO_BIT = 2;
  localparam int OPC4_LSB = 8;
  localparam int OPC7_LSB = 5;
  localparam int BIT_W = 3;
  localparam int PAGE_W = 2;
  localparam int PC_ZERO_BIT = 8;
  localparam logic [PC_W-1:0] PC_STEP = 11'h001;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [INSN_W-1:0] NOP_WORD = 12'h000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic [INSN_W-1:0] word;
    logic [PC_W-1:0] pc;
  } scc_fetch_t;

  typedef struct packed {
    logic we;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } scc_fwrite_t;

  typedef enum logic [2:0] {
    ST_EXEC = 3'h1,
    ST_FLUSH = 3'h2,
    ST_CALL2 = 3'h4
  } scc_state_t;

endpackage

// file: scc_decode.sv
`timescale 1ns/1ps
module scc_decode (
  // instruction
  input wire logic [scc_pkg::INSN_W-1:0] insn_i,
  // decoded class and fields
  output logic is_skip_o,
  output logic is_call_o,
  output logic is_clear_o,
  output logic [2:0] bit_sel_o,
  output logic [scc_pkg::FADDR_W-1:0] faddr_o,
  output logic [scc_pkg::DATA_W-1:0] lit_o
);
  assign is_skip_o = insn_i[scc_pkg::INSN_W-1:scc_pkg::OPC4_LSB] == scc_pkg::OPC_SKIP_SET;
  assign is_call_o = insn_i[scc_pkg::INSN_W-1:scc_pkg::OPC4_LSB] == scc_pkg::OPC_CALL;
  assign is_clear_o = insn_i[scc_pkg::INSN_W-1:scc_pkg::OPC7_LSB] == scc_pkg::OPC_CLEAR_F;
  assign bit_sel_o = insn_i[scc_pkg::BIT_LSB +: scc_pkg::BIT_W];
  assign faddr_o = insn_i[scc_pkg::FADDR_W-1:0];
  assign lit_o = insn_i[scc_pkg::DATA_W-1:0];
endmodule

// file: scc_core.sv
`timescale 1ns/1ps
module scc_core (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // fetch side
  input wire scc_pkg::scc_fetch_t fetch_i,
  // register file read port and status
  input wire logic [scc_pkg::DATA_W-1:0] frd_data_i,
  input wire logic [scc_pkg::DATA_W-1:0] status_i,
  // register file read address
  output logic [scc_pkg::FADDR_W-1:0] frd_addr_o,
  // register file write
  output scc_pkg::scc_fwrite_t fwr_o,
  // status zero flag set
  output logic zero_set_o,
  // program counter load
  output logic pc_load_o,
  output logic [scc_pkg::PC_W-1:0] pc_target_o,
  // stack push
  output logic push_o,
  output logic [scc_pkg::PC_W-1:0] stack_top_o,
  // execution status
  output logic flush_o,
  output logic busy_o
);

  // ****************************************
  // decode
  // ****************************************
  logic is_skip;
  logic is_call;
  logic is_clear;
  logic [scc_pkg::BIT_W-1:0] bit_sel;
  logic [scc_pkg::FADDR_W-1:0] faddr;
  logic [scc_pkg::DATA_W-1:0] lit;
  scc_pkg::scc_state_t state;
  scc_pkg::scc_state_t next_state;

  // prefetched word in flush or call-second cycle runs as a nop
  wire exec_live = fetch_i.valid && (state == scc_pkg::ST_EXEC);
  wire [scc_pkg::INSN_W-1:0] live_word = exec_live ? fetch_i.word : scc_pkg::NOP_WORD;

  scc_decode u_dec (
    .insn_i(live_word),
    .is_skip_o(is_skip),
    .is_call_o(is_call),
    .is_clear_o(is_clear),
    .bit_sel_o(bit_sel),
    .faddr_o(faddr),
    .lit_o(lit)
  );

  // ****************************************
  // execute
  // ****************************************
  // register file read is combinational, same cycle as decode
  assign frd_addr_o = faddr;
  wire bit_is_set = frd_data_i[bit_sel];
  wire do_skip = is_skip && bit_is_set;
  wire do_call = is_call;
  wire do_clear = is_clear;
  wire [scc_pkg::PC_W-1:0] call_target =
    {status_i[scc_pkg::STAT_PAGE_LSB +: scc_pkg::PAGE_W], 1'b0, lit};
  wire [scc_pkg::PC_W-1:0] ret_addr = fetch_i.pc + scc_pkg::PC_STEP;

  always_comb
  begin
    next_state = scc_pkg::ST_EXEC;
    case (state)
      scc_pkg::ST_EXEC:
      begin
        if (do_skip)
          next_state = scc_pkg::ST_FLUSH;
        else if (do_call)
          next_state = scc_pkg::ST_CALL2;
      end
      scc_pkg::ST_FLUSH: next_state = scc_pkg::ST_EXEC;
      scc_pkg::ST_CALL2: next_state = scc_pkg::ST_EXEC;
      default: next_state = scc_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      state <= scc_pkg::ST_EXEC;
    else
      state <= next_state;
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      fwr_o <= '0;
      zero_set_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_target_o <= '0;
      push_o <= 1'b0;
      stack_top_o <= '0;
      flush_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      fwr_o.we <= do_clear;
      fwr_o.addr <= faddr;
      fwr_o.data <= scc_pkg::ZERO_BYTE;
      zero_set_o <= do_clear;
      pc_load_o <= do_call;
      pc_target_o <= call_target;
      push_o <= do_call;
      stack_top_o <= ret_addr;
      flush_o <= do_skip || do_call;
      // from next_state so it stands during the inserted cycle itself
      busy_o <= next_state != scc_pkg::ST_EXEC;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence seq_call_taken;
    exec_live && is_call;
  endsequence

  sequence seq_skip_taken;
    exec_live && is_skip && frd_data_i[bit_sel];
  endsequence

  sequence seq_skip_passed;
    exec_live && is_skip && !frd_data_i[bit_sel];
  endsequence

  sequence seq_clear_taken;
    exec_live && is_clear;
  endsequence

  // the word on fetch_i here belongs to the discarded slot
  sequence seq_dead_cycle;
    state != scc_pkg::ST_EXEC;
  endsequence

  sequence seq_quiet;
    !fwr_o.we && !zero_set_o && !push_o && !pc_load_o && !flush_o;
  endsequence

  // one inserted cycle, then free again
  sequence seq_two_cycle;
    busy_o && flush_o ##1 !busy_o && !flush_o;
  endsequence

  // skip: flush the prefetched word
  AST_SKIP_FLUSH: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_skip_taken |=> flush_o && state == scc_pkg::ST_FLUSH ##1 state == scc_pkg::ST_EXEC)
    else $error("skip did not flush one cycle");
  AST_SKIP_TWO: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_skip_taken |=> seq_two_cycle)
    else $error("skip did not take two cycles");
  AST_SKIP_NO_EFFECT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_skip_taken |=> !fwr_o.we && !zero_set_o && !push_o && !pc_load_o)
    else $error("skip did more than flush");
  AST_SKIP_CLEAR_NO_FLUSH: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_skip_passed |=> !flush_o && !busy_o)
    else $error("skip flushed with bit clear");
  AST_FLUSH_PULSE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    flush_o |=> !flush_o)
    else $error("flush held longer than one cycle");
  AST_DEAD_NOP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_dead_cycle |=> seq_quiet)
    else $error("discarded word was executed");

  // call: push, load, two cycles
  AST_CALL_PUSH: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_call_taken |=> push_o && stack_top_o == $past(fetch_i.pc) + scc_pkg::PC_STEP)
    else $error("call return address wrong");
  AST_PUSH_WITH_LOAD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    push_o |-> pc_load_o && flush_o)
    else $error("push without a call");
  AST_CALL_LOW: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_call_taken |=> pc_load_o &&
      pc_target_o[scc_pkg::DATA_W-1:0] == $past(fetch_i.word[scc_pkg::DATA_W-1:0]))
    else $error("call low byte wrong");
  AST_CALL_PAGE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_call_taken |=> pc_target_o[scc_pkg::PC_W-1 -: scc_pkg::PAGE_W] ==
      $past(status_i[scc_pkg::STAT_PAGE_LSB +: scc_pkg::PAGE_W]))
    else $error("call page bits wrong");
  AST_CALL_TWO: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_call_taken |=> !pc_target_o[scc_pkg::PC_ZERO_BIT] && busy_o ##1 !busy_o && !pc_load_o)
    else $error("call not two cycles");
  AST_CALL_CYCLES: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_call_taken |=> seq_two_cycle)
    else $error("call flush and busy not one cycle");
  AST_BUSY_STATE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    busy_o |-> state != scc_pkg::ST_EXEC)
    else $error("busy without an inserted cycle");

  // clear: one cycle, zero written, zero flag set
  AST_CLEAR_WRITE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_clear_taken |=> fwr_o.we && fwr_o.data == scc_pkg::ZERO_BYTE && zero_set_o && !busy_o)
    else $error("clear write wrong");
  AST_CLEAR_ADDR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_clear_taken |=> fwr_o.addr == $past(fetch_i.word[scc_pkg::FADDR_W-1:0]))
    else $error("clear wrote the wrong register");
  AST_CLEAR_ONE_CYCLE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    seq_clear_taken |=> !flush_o && !push_o && !pc_load_o && !busy_o)
    else $error("clear did not finish in one cycle");
  AST_ZERO_ONLY_CLEAR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    zero_set_o |-> fwr_o.we && !push_o)
    else $error("zero flag set without clear");
  AST_WE_ZERO_DATA: assert property (@(posedge core_clk_i) disable iff (rst_i)
    fwr_o.we |-> zero_set_o && fwr_o.data == scc_pkg::ZERO_BYTE)
    else $error("file write without zero data");

endmodule

// file: test_skip_call_clear_exec.sv
`timescale 1ns/1ps
module test_skip_call_clear_exec;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  scc_pkg::scc_fetch_t fetch_i = '0;
  logic [7:0] frd_data_i = 8'h00;
  logic [7:0] status_i = 8'h00;
  logic [4:0] frd_addr_o;
  scc_pkg::scc_fwrite_t fwr_o;
  logic zero_set_o, pc_load_o, push_o, flush_o, busy_o;
  logic [10:0] pc_target_o, stack_top_o;
  int err_count = 0;
  int checked = 0;
  logic [31:0] seed = 32'h00008DD4;
  logic fetch_valid = 1'b1;
  scc_core uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .fetch_i(fetch_i),
    .frd_data_i(frd_data_i), .status_i(status_i), .frd_addr_o(frd_addr_o),
    .fwr_o(fwr_o), .zero_set_o(zero_set_o), .pc_load_o(pc_load_o),
    .pc_target_o(pc_target_o), .push_o(push_o), .stack_top_o(stack_top_o),
    .flush_o(flush_o), .busy_o(busy_o));
  always #25 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic bad(input string m);
    err_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp_b(input logic g, input logic e, input string m);
    checked++;
    if (g !== e) bad(m);
  endtask
  task automatic cmp_v(input logic [12:0] g, input logic [12:0] e, input string m);
    checked++;
    if (g !== e) bad(m);
  endtask
  task automatic give_verdict();
    $display("counts: checked %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one instruction, then the dead cycle where the design adds one
  task automatic do_op(input logic [11:0] w, input logic [10:0] p,
                       input logic [7:0] d, input logic [7:0] s);
    logic cl, tk, ca;
    logic [10:0] ra;
    logic [11:0] dw;
    ca = fetch_valid && (w[11:8] == 4'h9);
    cl = fetch_valid && (w[11:5] == 7'h03);
    tk = fetch_valid && (w[11:8] == 4'h7) && d[w[7:5]];
    ra = p + 11'h001;
    dw = seed[5] ? {7'h03, seed[4:0]} : {4'h9, seed[7:0]};
    fetch_i = '{fetch_valid, w, p};
    frd_data_i = d;
    status_i = s;
    #1;
    cmp_v(13'(frd_addr_o), fetch_valid ? 13'(w[4:0]) : 13'h0000, "read address");
    @(posedge core_clk_i);
    #2;
    cmp_b(flush_o, tk | ca, "flush");
    cmp_b(busy_o, tk | ca, "busy");
    cmp_b(push_o, ca, "push");
    cmp_b(pc_load_o, ca, "pc load");
    cmp_b(zero_set_o, cl, "zero set");
    cmp_b(fwr_o.we, cl, "write enable");
    if (ca) cmp_v(13'(stack_top_o), 13'(ra), "return");
    if (ca) cmp_v(13'(pc_target_o), {2'h0, s[6:5], 1'b0, w[7:0]}, "target");
    if (cl) cmp_v({fwr_o.addr, fwr_o.data}, {w[4:0], 8'h00}, "clear data");
    if (tk | ca)
    begin
      // a clear or a call here must be swallowed, not executed
      fetch_i = '{1'b1, dw, ra};
      @(posedge core_clk_i);
      #2;
      cmp_b(fwr_o.we | zero_set_o | push_o | pc_load_o, 1'b0, "dead op");
      cmp_b(busy_o | flush_o, 1'b0, "two cycles only");
    end
  endtask
  // every registered output sits at zero while reset is applied
  task automatic chk_reset();
    cmp_b(fwr_o.we | zero_set_o | pc_load_o | push_o, 1'b0, "reset pulses");
    cmp_b(flush_o | busy_o, 1'b0, "reset status");
    cmp_v({2'h0, pc_target_o}, 13'h0000, "reset target");
    cmp_v({2'h0, stack_top_o}, 13'h0000, "reset stack top");
  endtask
  initial
  begin
    logic [31:0] r;
    logic [11:0] w;
    repeat (6) @(posedge core_clk_i);
    #2;
    chk_reset();
    rst_i = 1'b0;
    @(posedge core_clk_i);
    #2;
    do_op(12'h7E0, 11'h010, 8'h80, 8'h00);
    do_op(12'h7FF, 11'h011, 8'h7F, 8'h00);
    do_op(12'h9FF, 11'h7FF, 8'h00, 8'hFF);
    do_op(12'h900, 11'h123, 8'hFF, 8'h9F);
    do_op(12'h900, 11'h124, 8'h00, 8'h40);
    do_op(12'h07F, 11'h200, 8'hFF, 8'h00);
    do_op(12'h060, 11'h201, 8'h00, 8'h04);
    // a word without valid must do nothing
    fetch_valid = 1'b0;
    do_op(12'h900, 11'h055, 8'hFF, 8'h60);
    do_op(12'h7E0, 11'h056, 8'hFF, 8'h00);
    fetch_valid = 1'b1;
    $display("test corners done");
    // reset in the dead cycle of a call leaves the core idle
    fetch_i = '{1'b1, 12'h9A5, 11'h300};
    @(posedge core_clk_i);
    #2;
    rst_i = 1'b1;
    fetch_i = '0;
    @(posedge core_clk_i);
    #2;
    chk_reset();
    rst_i = 1'b0;
    @(posedge core_clk_i);
    #2;
    do_op(12'h7E0, 11'h301, 8'h80, 8'h00);
    $display("test reset done");
    repeat (400)
    begin
      r = nxt();
      w = r[31:20];
      if (r[1:0] == 2'h0) w[11:8] = 4'h7;
      if (r[1:0] == 2'h1) w[11:8] = 4'h9;
      if (r[1:0] == 2'h2) w[11:5] = 7'h03;
      fetch_valid = r[3:2] != 2'h0;
      do_op(w, r[18:8], r[27:20] ^ r[7:0], 8'(nxt()));
    end
    fetch_valid = 1'b1;
    $display("test random done");
    give_verdict();
  end
  // about seven times the expected run length
  initial
  begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule
